/* psr_pkg.sv */
// Constants and types shared by the serial shift register block
package psr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PSR_STAGES     = 8;   // Stages in the chain
    localparam int PSR_FIFO_DEPTH = 16;  // Snapshot FIFO words
    localparam int PSR_AW         = 12;  // APB address width

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [PSR_AW-1:0] PSR_OFS_CTRL   = 12'h000;
    localparam logic [PSR_AW-1:0] PSR_OFS_STATUS = 12'h004;
    localparam logic [PSR_AW-1:0] PSR_OFS_DATA   = 12'h008;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PSR_CTRL_CAP_BIT   = 0;   // Capture snapshots into FIFO
    localparam int PSR_CTRL_INH_BIT   = 1;   // Software clock inhibit
    localparam int PSR_STAT_STAGE_LSB = 0;   // Stage contents
    localparam int PSR_STAT_LEVEL_LSB = 8;   // FIFO fill level, 5 bits
    localparam int PSR_STAT_FULL_BIT  = 16;  // FIFO full
    localparam int PSR_STAT_STALL_BIT = 17;  // Sticky: edge held off by full FIFO
    localparam int PSR_DATA_VALID_BIT = 8;   // Head word valid

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic PSR_RST_CAP = 1'b0;
    localparam logic PSR_RST_INH = 1'b0;

    // ------------------------------------------------------------
    // Bus side state, one packed struct
    // ------------------------------------------------------------
    typedef struct packed {
        logic        sclk_prev;  // Shift clock level at last edge
        logic        cap_en;     // Capture enable
        logic        soft_inh;   // Software inhibit
        logic        stall_flag; // Sticky stall flag
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } psr_state_type;

endpackage : psr_pkg

/* psr_fifo.sv */
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps

module psr_fifo
    import psr_pkg::*;
#(
    parameter int WIDTH = PSR_STAGES,
    parameter int DEPTH = PSR_FIFO_DEPTH
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   ce,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire logic [WIDTH-1:0]       in_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [WIDTH-1:0]            out_data,
    output logic [$clog2(DEPTH):0]      level
);

    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("psr_fifo: DEPTH must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("psr_fifo: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [PW:0] wptr;
        logic [PW:0] rptr;
    } psr_fifo_ptr_type;

    psr_fifo_ptr_type ptr_r;
    psr_fifo_ptr_type ptr_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // ------------------------------------------------------------
    // Flags, from the pointer difference
    // ------------------------------------------------------------
    assign level     = ptr_r.wptr - ptr_r.rptr;
    assign in_ready  = (level != (PW+1)'(DEPTH));  // Honest full
    assign out_valid = (level != '0);
    assign out_data  = mem[ptr_r.rptr[PW-1:0]];
    assign push      = ce & in_valid & in_ready;
    assign pop       = ce & out_valid & out_ready;

    // Pointer update
    always_comb begin
        ptr_nxt = ptr_r;
        if (push) begin
            ptr_nxt.wptr = ptr_r.wptr + 1'b1;
        end
        if (pop) begin
            ptr_nxt.rptr = ptr_r.rptr + 1'b1;
        end
    end

    // Storage has no reset; empty flag hides stale words
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[ptr_r.wptr[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_r <= '0;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

endmodule // psr_fifo

/* psr_shift.sv */
// Eight-stage parallel-in/serial-out shift register with APB status access
//
// How it works
// - Mode high: qualified edge shifts, serial input enters first stage.
// - Mode low: qualified edge loads all stages in parallel, serial ignored.
// - Parallel bit 0 feeds first stage; top bit feeds last stage.
// - Shifting: each stage takes neighbour's pre-edge value; output gets stage seven.
// - Only rising shift clock edges act; inhibit high holds all stages.
// - Inhibit low: free-running shift clock edges are honoured unless capture is on and the FIFO is full.
// - Clear low asynchronously zeroes all stages and output, overriding everything.
// - Serial bit reaches serial output after eight qualified shift edges.
`timescale 1ns/1ps

module psr_shift
    import psr_pkg::*;
#(
    parameter int STAGES     = PSR_STAGES,
    parameter int FIFO_DEPTH = PSR_FIFO_DEPTH
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [PSR_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Shift register pins
    input  wire logic              clear_n,
    input  wire logic              mode,
    input  wire logic              shift_clk,
    input  wire logic              clk_inhibit,
    input  wire logic              ser_in,
    input  wire logic [STAGES-1:0] par_in,
    output logic                   ser_out
);

    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (STAGES < 2 || STAGES > PSR_STAT_LEVEL_LSB) begin : g_bad_stages
        $error("psr_shift: STAGES must lie between 2 and 8");
    end
    if (LW > PSR_STAT_FULL_BIT - PSR_STAT_LEVEL_LSB) begin : g_bad_depth
        $error("psr_shift: FIFO_DEPTH too large for the status field");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    psr_state_type     st_r;
    psr_state_type     st_nxt;
    logic [STAGES-1:0] stage_r;
    logic [STAGES-1:0] stage_nxt;
    logic              shf_rst_n;
    logic              sclk_rise;
    logic              edge_ok;
    logic              step;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [STAGES-1:0] fifo_out_data;
    logic [LW-1:0]     fifo_level;
    logic              acc;
    logic              done;
    logic              rd_pop;

    // ------------------------------------------------------------
    // Shift clock qualification
    // ------------------------------------------------------------
    // Shift clock is sampled on pclk, so a rise is a low-to-high
    // change between two samples; no gate ever sits on a clock net.
    assign sclk_rise = shift_clk & ~st_r.sclk_prev;
    // Either inhibit source high blocks the edge, pin or software
    assign edge_ok   = sclk_rise & ~clk_inhibit & ~st_r.soft_inh;
    // A full FIFO holds the edge off instead of losing a snapshot;
    // the edge is gone, not delayed, so the stall flag reports it.
    assign step      = edge_ok & (~st_r.cap_en | fifo_in_ready);

    // ------------------------------------------------------------
    // Next stage values, one slice per bit
    // ------------------------------------------------------------
    for (genvar gi = 0; gi < STAGES; gi++) begin : g_stage
        if (gi == 0) begin : g_first
            // First stage takes serial input or parallel bit 0
            assign stage_nxt[gi] = mode ? ser_in : par_in[gi];
        end else begin : g_rest
            // Later stages take the neighbour's pre-edge value or their own parallel bit
            assign stage_nxt[gi] = mode ? stage_r[gi-1] : par_in[gi];
        end
    end

    // ------------------------------------------------------------
    // Stage flops
    // ------------------------------------------------------------
    // Clear acts without the clock and wins over every input; it
    // shares the async path with the bus reset.
    assign shf_rst_n = presetn & clear_n;

    always_ff @(posedge pclk or negedge shf_rst_n) begin
        if (!shf_rst_n) begin
            stage_r <= '0;
        end else if (ce && step) begin
            stage_r <= stage_nxt;
        end
    end

    // Output is the last stage flop directly
    assign ser_out = stage_r[STAGES-1];

    // ------------------------------------------------------------
    // Snapshot FIFO
    // ------------------------------------------------------------
    // Each accepted edge in capture mode pushes the chain as it stands after the edge.
    // Nothing is pushed while clear is held, as the chain stays zero.
    assign fifo_in_valid  = edge_ok & st_r.cap_en & clear_n;
    assign fifo_out_ready = rd_pop;

    psr_fifo #(
        .WIDTH (STAGES),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (stage_nxt),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // ------------------------------------------------------------
    // APB phase decode
    // ------------------------------------------------------------
    // pready rises in the second access cycle, so every transfer
    // has one wait state; the effect lands on the completing edge.
    assign acc    = psel & penable;
    assign done   = acc & st_r.pready;
    assign rd_pop = done & ~pwrite & (paddr == PSR_OFS_DATA) & fifo_out_valid;

    // ------------------------------------------------------------
    // Bus side next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        st_nxt.sclk_prev = shift_clk;
        st_nxt.pready    = acc & ~st_r.pready;

        // Read data and error are prepared the cycle before pready
        if (acc && !st_r.pready) begin
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata  = '0;
            unique case (paddr)
                PSR_OFS_CTRL: begin
                    st_nxt.prdata[PSR_CTRL_CAP_BIT] = st_r.cap_en;
                    st_nxt.prdata[PSR_CTRL_INH_BIT] = st_r.soft_inh;
                end
                PSR_OFS_STATUS: begin
                    st_nxt.prdata[PSR_STAT_STAGE_LSB +: STAGES] = stage_r;
                    st_nxt.prdata[PSR_STAT_LEVEL_LSB +: LW]     = fifo_level;
                    st_nxt.prdata[PSR_STAT_FULL_BIT]            = ~fifo_in_ready;
                    st_nxt.prdata[PSR_STAT_STALL_BIT]           = st_r.stall_flag;
                end
                PSR_OFS_DATA: begin
                    // Storage has no reset, so an empty head reads as zero, never stale or unknown
                    st_nxt.prdata[0 +: STAGES]          = fifo_out_valid ? fifo_out_data : '0;
                    st_nxt.prdata[PSR_DATA_VALID_BIT]   = fifo_out_valid;
                end
                default: begin
                    st_nxt.pslverr = 1'b1;  // Unmapped address
                end
            endcase
            // Writes to the data word are refused
            if (pwrite && paddr == PSR_OFS_DATA) begin
                st_nxt.pslverr = 1'b1;
            end
        end else if (done) begin
            st_nxt.pslverr = 1'b0;
            st_nxt.prdata  = '0;
        end

        // Register writes take effect on the completing edge
        if (done && pwrite) begin
            if (paddr == PSR_OFS_CTRL) begin
                st_nxt.cap_en   = pwdata[PSR_CTRL_CAP_BIT];
                st_nxt.soft_inh = pwdata[PSR_CTRL_INH_BIT];
            end
            if (paddr == PSR_OFS_STATUS && pwdata[PSR_STAT_STALL_BIT]) begin
                st_nxt.stall_flag = 1'b0;  // Write one to clear
            end
        end

        // A held-off edge sets the flag; set wins over a clear
        if (edge_ok && st_r.cap_en && !fifo_in_ready) begin
            st_nxt.stall_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bus side state register, frozen while ce is low
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r            <= '0;
            st_r.cap_en     <= PSR_RST_CAP;
            st_r.soft_inh   <= PSR_RST_INH;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Bus outputs come straight from the state flops
    assign prdata  = st_r.prdata;
    assign pready  = st_r.pready;
    assign pslverr = st_r.pslverr;

endmodule // psr_shift

/* psr_shift_properties.sv */
// Concurrent checks on the shift register block ports
`timescale 1ns/1ps

module psr_shift_properties
    import psr_pkg::*;
#(
    parameter int STAGES     = PSR_STAGES,
    parameter int FIFO_DEPTH = PSR_FIFO_DEPTH
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              ce,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [PSR_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              clear_n,
    input wire logic              mode,
    input wire logic              shift_clk,
    input wire logic              clk_inhibit,
    input wire logic              ser_in,
    input wire logic [STAGES-1:0] par_in,
    input wire logic              ser_out
);
    // ------------------------------------------------------------
    // Shadow of control bits and of the chain
    // ------------------------------------------------------------
    logic              prev_r;
    logic              cap_r;
    logic              inh_r;
    logic              trk_r;
    logic [STAGES-1:0] shadow_r;
    logic              step;

    // Steps outside capture mode only; in capture mode a full FIFO may drop steps, so we stop trusting it
    assign step = ce && clear_n && shift_clk && !prev_r && !clk_inhibit && !inh_r && !cap_r;

    // Shadow follows qualified steps; clear makes it trustworthy again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {prev_r, cap_r, inh_r, shadow_r} <= '0;
            trk_r <= 1'b1;
        end else begin
            if (ce) prev_r <= shift_clk;
            if (psel && penable && pready && pwrite && paddr == PSR_OFS_CTRL) {inh_r, cap_r} <= pwdata[1:0];
            if (!clear_n) begin
                shadow_r <= '0;
                trk_r    <= 1'b1;
            end else if (cap_r) trk_r <= 1'b0;
            else if (step) shadow_r <= mode ? {shadow_r[STAGES-2:0], ser_in} : par_in;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_chain_out: assert property (trk_r && clear_n |-> ser_out == shadow_r[STAGES-1])
        else $error("serial output differs from the reference chain");
    a_rise_acts: assert property (step && mode && trk_r |=> !clear_n || ser_out == $past(shadow_r[STAGES-2]))
        else $error("shift did not move the seventh stage to the output");
    a_load_last: assert property (step && !mode |=> !clear_n || ser_out == $past(par_in[STAGES-1]))
        else $error("parallel load did not put the top bit on the output");
    a_stat_out: assert property (pready && !pwrite && paddr == PSR_OFS_STATUS |-> prdata[STAGES-1] == $past(ser_out))
        else $error("last stage in status differs from serial output");
    a_inhibit_hold: assert property (clk_inhibit |=> !clear_n || $stable(ser_out))
        else $error("output moved while clock inhibit was high");
    a_no_rise_hold: assert property (clear_n && !(shift_clk && !prev_r) |=> !clear_n || $stable(ser_out))
        else $error("output moved without a rising shift clock");
    a_soft_inhibit: assert property (inh_r |=> !clear_n || $stable(ser_out))
        else $error("output moved while software inhibit was set");
    a_clear_zero: assert property (!clear_n |-> !ser_out)
        else $error("serial output not zero during clear");
    a_ce_freeze: assert property (!ce |=> !clear_n || $stable(ser_out))
        else $error("output moved while clock enable was low");

    c_shift: cover property (step && mode);
    c_load: cover property (step && !mode);
    c_error: cover property (pready && pslverr);

endmodule // psr_shift_properties

bind psr_shift psr_shift_properties #(.STAGES(STAGES), .FIFO_DEPTH(FIFO_DEPTH)) psr_shift_properties_inst (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .clear_n(clear_n), .mode(mode),
    .shift_clk(shift_clk), .clk_inhibit(clk_inhibit), .ser_in(ser_in), .par_in(par_in), .ser_out(ser_out));

/* psr_ctrl_model.sv */
// Behavioural controller that drives the shift register pins
`timescale 1ns/1ps

module psr_ctrl_model (
    input  wire logic  pclk,
    output logic       clear_n,
    output logic       mode,
    output logic       shift_clk,
    output logic       clk_inhibit,
    output logic       ser_in,
    output logic [7:0] par_in
);
    // Idle: clear released, shift mode, clock low
    initial begin
        {clear_n, mode, shift_clk, clk_inhibit, ser_in, par_in} = 13'h1800;
    end

    // One low sample then a rise; data held to the rise, then scrambled
    task automatic step(input logic m, input logic s, input logic [7:0] p);
        @(posedge pclk);
        shift_clk <= 1'b0;
        mode      <= m;
        ser_in    <= s;
        par_in    <= p;
        @(posedge pclk);
        shift_clk <= 1'b1;
        @(posedge pclk);
        ser_in    <= ~s; // Hold over, show stale data as wrong
        par_in    <= ~p;
    endtask

    // Steps leave the clock high, so raising inhibit here adds no edge
    task automatic set_inh(input logic v);
        @(posedge pclk);
        clk_inhibit <= v;
    endtask

    task automatic set_clr(input logic v);
        @(posedge pclk);
        clear_n <= v;
    endtask
endmodule // psr_ctrl_model

/* tb_top.sv */
// Self-checking bench for the shift register block with APB access
`timescale 1ns/1ps

module tb_top;
    import psr_pkg::*;

    logic              pclk;
    logic              presetn;
    logic              ce;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [PSR_AW-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              clear_n;
    logic              mode;
    logic              shift_clk;
    logic              clk_inhibit;
    logic              ser_in;
    logic [7:0]        par_in;
    logic              ser_out;
    logic [32:0]       expq[$];
    logic [7:0]        snaps[$];
    logic [7:0]        mdl;
    logic [4:0]        lvl;
    logic              stall;
    logic [31:0]       rnd;
    int                n_fail;
    int                compares;
    int                seed;

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    psr_ctrl_model psr_ctrl_model_inst (.pclk(pclk), .clear_n(clear_n), .mode(mode), .shift_clk(shift_clk),
        .clk_inhibit(clk_inhibit), .ser_in(ser_in), .par_in(par_in));
    psr_shift psr_shift_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clear_n(clear_n), .mode(mode), .shift_clk(shift_clk), .clk_inhibit(clk_inhibit), .ser_in(ser_in),
        .par_in(par_in), .ser_out(ser_out));

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Each completed transfer is compared with the oldest expectation
    always @(posedge pclk) begin
        if (presetn && pready === 1'b1) begin
            if (expq.size() == 0) n_fail++;
            else check({pslverr, pwrite ? 32'h0 : prdata}, expq.pop_front());
        end
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [PSR_AW-1:0] a, input logic [31:0] d, input logic [32:0] e);
        int i = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        expq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            stop_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stat;
        apb(1'b0, PSR_OFS_STATUS, 32'h0, {1'b0, 14'h0, stall, lvl == 5'd16, 3'h0, lvl, mdl});
    endtask

    // A refused step leaves the reference chain untouched
    task automatic step(input logic m, input logic s, input logic [7:0] p, input logic blk);
        psr_ctrl_model_inst.step(m, s, p);
        if (!blk) mdl = m ? {mdl[6:0], s} : p;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        {mdl, lvl, stall, n_fail, compares} = '0;
        seed = 57;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PSR_OFS_CTRL, 32'h0, 33'h0);
        stat();
        repeat (24) begin
            rnd = $random(seed);
            step(rnd[0], rnd[1], rnd[15:8], 1'b0);
            stat();
        end
        step(1'b1, 1'b1, 8'h00, 1'b0);
        repeat (7) step(1'b1, 1'b0, 8'hff, 1'b0);
        #1 check({32'h0, ser_out}, 33'h1);
        psr_ctrl_model_inst.set_inh(1'b1);
        step(1'b0, 1'b0, 8'h5a, 1'b1);
        stat();
        psr_ctrl_model_inst.set_inh(1'b0);
        // Clock enable low freezes the chain through a whole step
        ce <= 1'b0;
        step(1'b0, 1'b0, 8'h3c, 1'b1);
        ce <= 1'b1;
        stat();
        apb(1'b1, PSR_OFS_CTRL, 32'h2, 33'h0);
        step(1'b0, 1'b0, 8'ha5, 1'b1);
        apb(1'b0, PSR_OFS_CTRL, 32'h0, 33'h2);
        apb(1'b1, PSR_OFS_CTRL, 32'h0, 33'h0);
        stat();
        psr_ctrl_model_inst.set_clr(1'b0);
        step(1'b0, 1'b0, 8'hff, 1'b1);
        mdl = 8'h0;
        #1 check({32'h0, ser_out}, 33'h0);
        stat();
        psr_ctrl_model_inst.set_clr(1'b1);
        // Unmapped places and the read-only data word answer with an error
        apb(1'b0, 12'h00c, 32'h0, {1'b1, 32'h0});
        apb(1'b1, PSR_OFS_DATA, 32'h1, {1'b1, 32'h0});
        apb(1'b1, 12'hffc, 32'h1, {1'b1, 32'h0});
        // Fill the FIFO until a step is refused, then drain it
        apb(1'b1, PSR_OFS_CTRL, 32'h1, 33'h0);
        repeat (17) begin
            rnd = $random(seed);
            step(1'b1, rnd[0], 8'h0, lvl == 5'd16);
            if (lvl == 5'd16) stall = 1'b1;
            else begin
                snaps.push_back(mdl);
                lvl++;
            end
        end
        stat();
        apb(1'b0, PSR_OFS_CTRL, 32'h0, 33'h1);
        apb(1'b1, PSR_OFS_CTRL, 32'h0, 33'h0);
        while (snaps.size() > 0) begin
            lvl--;
            apb(1'b0, PSR_OFS_DATA, 32'h0, {25'h1, snaps.pop_front()});
        end
        // Empty FIFO: valid low and the head reads as zero
        apb(1'b0, PSR_OFS_DATA, 32'h0, 33'h0);
        stat();
        apb(1'b1, PSR_OFS_STATUS, 32'h20000, 33'h0);
        stall = 1'b0;
        stat();
        repeat (4) @(posedge pclk);
        stop_test();
    end
endmodule // tb_top
